/* File: common/cmb_map.svh */
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH

// Command codes.
`define CMB_CODE_CLEAR_FAULTS  8'h03
`define CMB_CODE_STORE_ALL     8'h11
`define CMB_CODE_RESTORE_ALL   8'h12
`define CMB_CODE_VOUT_COMMAND  8'h21
`define CMB_CODE_MARGIN_HIGH   8'hD5
`define CMB_CODE_MARGIN_LOW    8'hD6
`define CMB_CODE_OPTIONS       8'hE5
`define CMB_CODE_MISC          8'hF0

// Miscellaneous options register fields.
`define CMB_MISC_OV_BEHAVIOUR  0
`define CMB_MISC_TRIM_LSB      1
`define CMB_MISC_LEVEL_SHIFT   4
`define CMB_MISC_SYNC_OUT      6
`define CMB_MISC_SYNC_IN       7
`define CMB_MISC_SYNC_MASK     8
`define CMB_MISC_WMASK         16'h01D7
`define CMB_MISC_RESET         16'h0013

// Options register fields.
`define CMB_OPT_AUTO_ALERT     7
`define CMB_OPT_RANGE_LSB      8
`define CMB_OPT_CMD_RESTORE    11
`define CMB_OPT_MARGIN_LOW     13
`define CMB_OPT_MARGIN_HIGH    14
`define CMB_OPT_WMASK          16'h6B80
`define CMB_OPT_RESET          16'h0180

// Restore values.
`define CMB_MARGIN_LOW_VAL0    16'hFFF7
`define CMB_MARGIN_LOW_VAL1    16'hFFF1
`define CMB_MARGIN_HIGH_VAL0   16'h0009
`define CMB_MARGIN_HIGH_VAL1   16'h000F
`define CMB_VOUT_DEFAULT       16'h0200

// Timing.
`define CMB_CLK_PERIOD_NS      4
`define CMB_SYNC_LOSS_NS       8000
`define CMB_SYNC_LOSS_CYC      (`CMB_SYNC_LOSS_NS / `CMB_CLK_PERIOD_NS)

`endif

/* File: common/cmb_pkg.sv */
package cmb_pkg;
	typedef enum logic [1:0] {
		CMB_DIV_HALF,
		CMB_DIV_QUARTER,
		CMB_DIV_EIGHTH
	} cmb_div_type;
endpackage : cmb_pkg

/* File: dv/cmb_config_tb_top.sv */
`timescale 1ns/1ps

`define CMB_CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module cmb_config_tb_top;
	import cmb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid, cmd_write, rsp_valid_q;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_data_q, r;
	logic [1:0] loop_scale_code = 2'h0;
	logic [3:0] sd = 4'h0;
	logic ov_det = 1'b0, ov_ign = 1'b0, startup = 1'b0, dis = 1'b0, feedback_low = 1'b0;
	logic drv_sw = 1'b0, ara = 1'b0, sync_run = 1'b0, sync_in, sync_out_q, sync_oe_q;
	logic [7:0] fault_sources = 8'h00;
	cmb_div_type meas_divider_q;
	logic [15:0] vout_q, mhi_q, mlo_q;
	logic fet_q, ls_q, pwm_clk_q, sync_fault_q, smbalert_q;
	logic [2:0] trim_q;
	logic [2:0] trim_tab [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
	int errors = 0;
	int checked = 0;
	int n;

	cmb_config #(.FREERUN_HALF(8'h04)) dut_u (.clock(clock), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
		.loop_scale_code(loop_scale_code), .fault_shutdown(sd[0]), .fault_restart(sd[1]),
		.control_shutdown(sd[2]), .low_vin(sd[3]), .ov_fault_det(ov_det),
		.ov_action_ignore(ov_ign), .output_startup(startup), .disable_state(dis),
		.feedback_below_limit(feedback_low), .driver_switching(drv_sw), .ara_done(ara),
		.fault_sources(fault_sources), .sync_in(sync_in), .sync_out_q(sync_out_q),
		.sync_oe_q(sync_oe_q), .meas_divider_q(meas_divider_q), .vout_command_q(vout_q),
		.margin_high_q(mhi_q), .margin_low_q(mlo_q), .lowside_fet_on_q(fet_q),
		.oc_trim_eighths_q(trim_q), .level_shifter_on_q(ls_q), .pwm_clk_q(pwm_clk_q),
		.sync_fault_q(sync_fault_q), .smbalert_q(smbalert_q));

	cmb_host_model host_u (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q),
		.rsp_data_q(rsp_data_q), .sync_run(sync_run), .sync_out_q(sync_out_q),
		.sync_oe_q(sync_oe_q), .sync_in(sync_in));

	initial begin
		forever #2 clock = ~clock;
	end

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host_u.xfer(1'b1, c, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] c);
		host_u.xfer(1'b0, c, 16'h0000, r);
	endtask : rd

	task automatic wait_n(input int k);
		repeat (k) @(negedge clock);
	endtask : wait_n

	// Counts rising edges of the sync output or of the switching clock.
	task automatic rises(input logic sel, input int cyc);
		logic p;
		n = 0;
		p = sel ? sync_out_q : pwm_clk_q;
		repeat (cyc) begin
			@(negedge clock);
			if ((sel ? sync_out_q : pwm_clk_q) === 1'b1 && p !== 1'b1)
				n++;
			p = sel ? sync_out_q : pwm_clk_q;
		end
	endtask : rises

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		#100000;
		errors++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		rd(8'hF0); `CMB_CHK("misc_reset", 16'h0013, r)
		rd(8'hE5); `CMB_CHK("opt_reset", 16'h0180, r)
		`CMB_CHK("mhi_reset", 16'h0009, mhi_q)
		`CMB_CHK("mlo_reset", 16'hFFF7, mlo_q)
		rd(8'h77); `CMB_CHK("unmapped", 16'h0000, r)
		wr(8'hF0, 16'hFFFF);
		rd(8'hF0); `CMB_CHK("misc_rsvd", 16'h01D7, r)
		for (int i = 0; i < 4; i++) begin
			wr(8'hF0, 16'(i << 1));
			`CMB_CHK("trim", trim_tab[i], trim_q)
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'hE5, 16'h0080 | 16'((3 - i) << 8));
			`CMB_CHK("div_forced", cmb_div_type'(i), meas_divider_q)
			loop_scale_code = 2'(i);
			wr(8'hE5, 16'h0080);
			`CMB_CHK("div_scale", cmb_div_type'(i), meas_divider_q)
		end
		wr(8'hE5, 16'h6880);
		wr(8'hF0, 16'h0081);
		wr(8'h11, 16'h0000);
		wr(8'hE5, 16'h0080);
		wr(8'hF0, 16'h0000);
		wr(8'h12, 16'h0000);
		`CMB_CHK("mhi_sel1", 16'h000F, mhi_q)
		`CMB_CHK("mlo_sel1", 16'hFFF1, mlo_q)
		rd(8'hF0); `CMB_CHK("misc_stored", 16'h0081, r)
		for (int i = 0; i < 4; i++) begin
			wr(8'h21, 16'h1234);
			`CMB_CHK("vout_set", 16'h1234, vout_q)
			sd[i] = 1'b1;
			wait_n(1);
			sd[i] = 1'b0;
			wait_n(2);
			`CMB_CHK("vout_restore", 16'h0200, vout_q)
		end
		wr(8'hE5, 16'h0080);
		wr(8'h21, 16'h1234);
		sd[2] = 1'b1;
		wait_n(1);
		sd[2] = 1'b0;
		wait_n(2);
		`CMB_CHK("vout_kept", 16'h1234, vout_q)
		ov_det = 1'b1;
		wait_n(1);
		ov_det = 1'b0;
		wait_n(1);
		`CMB_CHK("fet_on", 1'b1, fet_q)
		feedback_low = 1'b1;
		wait_n(6);
		`CMB_CHK("fet_feedback_off", 1'b0, fet_q)
		feedback_low = 1'b0;
		ov_ign = 1'b1;
		ov_det = 1'b1;
		wait_n(1);
		ov_det = 1'b0;
		wait_n(1);
		`CMB_CHK("fet_ignore", 1'b0, fet_q)
		ov_ign = 1'b0;
		wr(8'hF0, 16'h0000);
		ov_det = 1'b1;
		wait_n(1);
		ov_det = 1'b0;
		feedback_low = 1'b1;
		wait_n(6);
		`CMB_CHK("fet_held", 1'b1, fet_q)
		feedback_low = 1'b0;
		wr(8'h03, 16'h0000);
		`CMB_CHK("fet_clr_enabled", 1'b1, fet_q)
		dis = 1'b1;
		wr(8'h03, 16'h0000);
		`CMB_CHK("fet_clr_disabled", 1'b0, fet_q)
		dis = 1'b0;
		ov_det = 1'b1;
		wait_n(1);
		ov_det = 1'b0;
		startup = 1'b1;
		wait_n(1);
		startup = 1'b0;
		wait_n(1);
		`CMB_CHK("fet_startup", 1'b0, fet_q)
		wr(8'hF0, 16'h0010);
		drv_sw = 1'b1;
		wait_n(2);
		`CMB_CHK("ls_latched", 1'b1, ls_q)
		wr(8'hF0, 16'h0000);
		`CMB_CHK("ls_frozen", 1'b1, ls_q)
		drv_sw = 1'b0;
		wait_n(2);
		drv_sw = 1'b1;
		wait_n(2);
		`CMB_CHK("ls_off", 1'b0, ls_q)
		drv_sw = 1'b0;
		wr(8'hF0, 16'h0040);
		`CMB_CHK("sync_oe", 1'b1, sync_oe_q)
		rises(1'b1, 40);
		`CMB_CHK("sync_out_run", 1'b1, n >= 4 && n <= 6)
		wr(8'hF0, 16'h0180);
		`CMB_CHK("sync_oe_off", 1'b0, sync_oe_q)
		sync_run = 1'b1;
		rises(1'b0, 240);
		`CMB_CHK("pwm_follow", 1'b1, n >= 18 && n <= 21)
		sync_run = 1'b0;
		wait_n(2100);
		`CMB_CHK("sync_fault_masked", 1'b0, sync_fault_q)
		wr(8'hF0, 16'h0080);
		wait_n(2100);
		`CMB_CHK("sync_fault", 1'b1, sync_fault_q)
		fault_sources = 8'h01;
		wait_n(3);
		`CMB_CHK("alert_on", 1'b1, smbalert_q)
		ara = 1'b1;
		wait_n(1);
		ara = 1'b0;
		wait_n(4);
		`CMB_CHK("alert_masked", 1'b0, smbalert_q)
		finish_test();
	end
endmodule : cmb_config_tb_top

/* File: dv/cmb_host_model.sv */
`timescale 1ns/1ps

module cmb_host_model (
	// Clock.
	input  wire logic        clock,
	// Command port.
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [15:0]      cmd_wdata,
	input  wire logic        rsp_valid_q,
	input  wire logic [15:0] rsp_data_q,
	// Sync pin.
	input  wire logic        sync_run,
	input  wire logic        sync_out_q,
	input  wire logic        sync_oe_q,
	output logic             sync_in
);
	logic ext_clk = 1'b0;

	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// The external clock stands still while it is not running.
	always #24 ext_clk = sync_run ? ~ext_clk : 1'b0;

	// The device wins the pin while it drives it.
	assign sync_in = sync_oe_q ? sync_out_q : ext_clk;

	// One command, held through the taking edge; read data caught when valid.
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] r);
		int n;
		r = 'x;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code  = c;
		cmd_wdata = d;
		@(negedge clock);
		cmd_valid = 1'b0;
		cmd_code  = ~c;
		cmd_wdata = ~d;
		for (n = 0; n < 3; n++) begin
			if (!w && rsp_valid_q === 1'b1)
				r = rsp_data_q;
			@(negedge clock);
		end
	endtask : xfer
endmodule : cmb_host_model

/* File: verilog/cmb_config.sv */
`timescale 1ns/1ps
`include "cmb_map.svh"

module cmb_config
	import cmb_pkg::*;
#(
	parameter logic [7:0] FREERUN_HALF = 8'h20
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// Command port.
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic             rsp_valid_q,
	output logic [15:0]      rsp_data_q,
	// Converter events.
	input  wire logic [1:0]  loop_scale_code,
	input  wire logic        fault_shutdown,
	input  wire logic        fault_restart,
	input  wire logic        control_shutdown,
	input  wire logic        low_vin,
	input  wire logic        ov_fault_det,
	input  wire logic        ov_action_ignore,
	input  wire logic        output_startup,
	input  wire logic        disable_state,
	input  wire logic        feedback_below_limit,
	input  wire logic        driver_switching,
	input  wire logic        ara_done,
	input  wire logic [7:0]  fault_sources,
	// Sync pin.
	input  wire logic        sync_in,
	output logic             sync_out_q,
	output logic             sync_oe_q,
	// Controls and status.
	output cmb_div_type      meas_divider_q,
	output logic [15:0]      vout_command_q,
	output logic [15:0]      margin_high_q,
	output logic [15:0]      margin_low_q,
	output logic             lowside_fet_on_q,
	output logic [2:0]       oc_trim_eighths_q,
	output logic             level_shifter_on_q,
	output logic             pwm_clk_q,
	output logic             sync_fault_q,
	output logic             smbalert_q
);
	logic [15:0] misc_q, misc_d, opt_q, opt_d, nvm_misc_q, nvm_misc_d, nvm_opt_q, nvm_opt_d;
	logic [15:0] vout_d, mhi_d, mlo_d, rsp_data_d;
	logic [7:0]  fr_cnt_q, fr_cnt_d, alert_mask_q, alert_mask_d;
	logic [11:0] loss_cnt_q, loss_cnt_d;
	logic        rsp_valid_d, fet_d, ls_d, sw_prev_q, freerun_q, freerun_d;
	logic        pwm_d, sync_fault_d, alert_d, sync_oe_d, sync_out_d, lost;
	logic [2:0]  trim_d;
	cmb_div_type div_d;
	logic        sync_lvl, sync_rise, feedback_low;

	cmb_sync_edge u_sync_pin (
		.clock    (clock),
		.rst      (rst),
		.async_in (sync_in),
		.level_q  (sync_lvl),
		.rise_q   (sync_rise)
	);

	cmb_sync_edge u_feedback_cmp (
		.clock    (clock),
		.rst      (rst),
		.async_in (feedback_below_limit),
		.level_q  (feedback_low),
		.rise_q   ()
	);

	function automatic logic is_write(input logic [7:0] code);
		return cmd_valid && cmd_write && (cmd_code == code);
	endfunction : is_write

	assign lost = (loss_cnt_q == 12'(`CMB_SYNC_LOSS_CYC));

	always_comb begin
		misc_d       = misc_q;
		opt_d        = opt_q;
		nvm_misc_d   = nvm_misc_q;
		nvm_opt_d    = nvm_opt_q;
		vout_d       = vout_command_q;
		mhi_d        = margin_high_q;
		mlo_d        = margin_low_q;
		rsp_valid_d  = cmd_valid && !cmd_write;
		rsp_data_d   = 16'h0000;
		if (cmd_valid && !cmd_write) begin
			case (cmd_code)
				`CMB_CODE_MISC:         rsp_data_d = misc_q;
				`CMB_CODE_OPTIONS:      rsp_data_d = opt_q;
				`CMB_CODE_VOUT_COMMAND: rsp_data_d = vout_command_q;
				`CMB_CODE_MARGIN_HIGH:  rsp_data_d = margin_high_q;
				`CMB_CODE_MARGIN_LOW:   rsp_data_d = margin_low_q;
				default:                rsp_data_d = 16'h0000;
			endcase
		end
		if (is_write(`CMB_CODE_MISC)) begin
			misc_d = cmd_wdata & `CMB_MISC_WMASK;
		end
		if (is_write(`CMB_CODE_OPTIONS)) begin
			opt_d = cmd_wdata & `CMB_OPT_WMASK;
		end
		if (is_write(`CMB_CODE_VOUT_COMMAND)) begin
			vout_d = cmd_wdata;
		end
		if (is_write(`CMB_CODE_MARGIN_HIGH)) begin
			mhi_d = cmd_wdata;
		end
		if (is_write(`CMB_CODE_MARGIN_LOW)) begin
			mlo_d = cmd_wdata;
		end
		if (is_write(`CMB_CODE_STORE_ALL)) begin
			nvm_misc_d = misc_q;
			nvm_opt_d  = opt_q;
		end
		if (is_write(`CMB_CODE_RESTORE_ALL)) begin
			misc_d = nvm_misc_q;
			opt_d  = nvm_opt_q;
			vout_d = `CMB_VOUT_DEFAULT;
			mlo_d  = nvm_opt_q[`CMB_OPT_MARGIN_LOW] ? `CMB_MARGIN_LOW_VAL1
				: `CMB_MARGIN_LOW_VAL0;
			mhi_d  = nvm_opt_q[`CMB_OPT_MARGIN_HIGH] ? `CMB_MARGIN_HIGH_VAL1
				: `CMB_MARGIN_HIGH_VAL0;
		end
		if (opt_q[`CMB_OPT_CMD_RESTORE]
			&& (fault_shutdown || fault_restart || control_shutdown || low_vin)) begin
			vout_d = `CMB_VOUT_DEFAULT;
		end
		case (opt_q[`CMB_OPT_RANGE_LSB +: 2])
			2'b11:   div_d = CMB_DIV_HALF;
			2'b10:   div_d = CMB_DIV_QUARTER;
			2'b01:   div_d = CMB_DIV_EIGHTH;
			default: begin
				case (loop_scale_code)
					2'b01:   div_d = CMB_DIV_QUARTER;
					2'b10:   div_d = CMB_DIV_EIGHTH;
					default: div_d = CMB_DIV_HALF;
				endcase
			end
		endcase
		fet_d = lowside_fet_on_q;
		if (misc_q[`CMB_MISC_OV_BEHAVIOUR]) begin
			if (feedback_low) begin
				fet_d = 1'b0;
			end
		end else if (output_startup
			|| (is_write(`CMB_CODE_CLEAR_FAULTS) && disable_state)) begin
			fet_d = 1'b0;
		end
		if (ov_fault_det && !ov_action_ignore) begin
			fet_d = 1'b1;
		end
		case (misc_q[`CMB_MISC_TRIM_LSB +: 2])
			2'b01:   trim_d = 3'h1;
			2'b10:   trim_d = 3'h6;
			2'b11:   trim_d = 3'h7;
			default: trim_d = 3'h0;
		endcase
		ls_d = level_shifter_on_q;
		if (driver_switching && !sw_prev_q) begin
			ls_d = misc_q[`CMB_MISC_LEVEL_SHIFT];
		end
		fr_cnt_d  = fr_cnt_q + 8'h01;
		freerun_d = freerun_q;
		if (fr_cnt_q >= FREERUN_HALF - 8'h01) begin
			fr_cnt_d  = 8'h00;
			freerun_d = ~freerun_q;
		end
		sync_oe_d  = misc_q[`CMB_MISC_SYNC_OUT];
		sync_out_d = misc_q[`CMB_MISC_SYNC_OUT] & freerun_q;
		loss_cnt_d = loss_cnt_q;
		if (!misc_q[`CMB_MISC_SYNC_IN] || sync_rise) begin
			loss_cnt_d = 12'h000;
		end else if (!lost) begin
			loss_cnt_d = loss_cnt_q + 12'h001;
		end
		sync_fault_d = lost && !misc_q[`CMB_MISC_SYNC_MASK];
		if (misc_q[`CMB_MISC_SYNC_IN] && !sync_fault_d) begin
			pwm_d = sync_lvl;
		end else begin
			pwm_d = freerun_q;
		end
		alert_mask_d = alert_mask_q;
		if (is_write(`CMB_CODE_CLEAR_FAULTS)) begin
			alert_mask_d = 8'h00;
		end
		if (ara_done && opt_q[`CMB_OPT_AUTO_ALERT]) begin
			alert_mask_d = alert_mask_q | fault_sources;
		end
		alert_d = |(fault_sources & ~alert_mask_q);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			misc_q             <= `CMB_MISC_RESET;
			opt_q              <= `CMB_OPT_RESET;
			nvm_misc_q         <= `CMB_MISC_RESET;
			nvm_opt_q          <= `CMB_OPT_RESET;
			vout_command_q     <= `CMB_VOUT_DEFAULT;
			margin_high_q      <= `CMB_MARGIN_HIGH_VAL0;
			margin_low_q       <= `CMB_MARGIN_LOW_VAL0;
			rsp_valid_q        <= 1'b0;
			rsp_data_q         <= 16'h0000;
			meas_divider_q     <= CMB_DIV_HALF;
			lowside_fet_on_q   <= 1'b0;
			oc_trim_eighths_q  <= 3'h0;
			level_shifter_on_q <= 1'b0;
			sw_prev_q          <= 1'b0;
			fr_cnt_q           <= 8'h00;
			freerun_q          <= 1'b0;
			sync_oe_q          <= 1'b0;
			sync_out_q         <= 1'b0;
			loss_cnt_q         <= 12'h000;
			sync_fault_q       <= 1'b0;
			pwm_clk_q          <= 1'b0;
			alert_mask_q       <= 8'h00;
			smbalert_q         <= 1'b0;
		end else begin
			misc_q             <= misc_d;
			opt_q              <= opt_d;
			nvm_misc_q         <= nvm_misc_d;
			nvm_opt_q          <= nvm_opt_d;
			vout_command_q     <= vout_d;
			margin_high_q      <= mhi_d;
			margin_low_q       <= mlo_d;
			rsp_valid_q        <= rsp_valid_d;
			rsp_data_q         <= rsp_data_d;
			meas_divider_q     <= div_d;
			lowside_fet_on_q   <= fet_d;
			oc_trim_eighths_q  <= trim_d;
			level_shifter_on_q <= ls_d;
			sw_prev_q          <= driver_switching;
			fr_cnt_q           <= fr_cnt_d;
			freerun_q          <= freerun_d;
			sync_oe_q          <= sync_oe_d;
			sync_out_q         <= sync_out_d;
			loss_cnt_q         <= loss_cnt_d;
			sync_fault_q       <= sync_fault_d;
			pwm_clk_q          <= pwm_d;
			alert_mask_q       <= alert_mask_d;
			smbalert_q         <= alert_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_ov_taken;
		ov_fault_det && !ov_action_ignore;
	endsequence

	sequence s_fet_held;
		lowside_fet_on_q && !misc_q[`CMB_MISC_OV_BEHAVIOUR] && !output_startup
			&& !(cmd_valid && cmd_write && cmd_code == `CMB_CODE_CLEAR_FAULTS);
	endsequence

	property p_range_fixed;
		opt_q[`CMB_OPT_RANGE_LSB +: 2] == 2'b10 |=> meas_divider_q == CMB_DIV_QUARTER;
	endproperty
	a_range_fixed: assert property (p_range_fixed) else $error("Divider not quarter.");

	property p_range_loop;
		opt_q[`CMB_OPT_RANGE_LSB +: 2] == 2'b00 && loop_scale_code == 2'b10
			|=> meas_divider_q == CMB_DIV_EIGHTH;
	endproperty
	a_range_loop: assert property (p_range_loop) else $error("Divider not eighth.");

	property p_cmd_restore;
		opt_q[`CMB_OPT_CMD_RESTORE] && (fault_restart || low_vin)
			|=> vout_command_q == `CMB_VOUT_DEFAULT;
	endproperty
	a_cmd_restore: assert property (p_cmd_restore) else $error("Command not reloaded.");

	property p_margin_low;
		cmd_valid && cmd_write && cmd_code == `CMB_CODE_RESTORE_ALL
			&& nvm_opt_q[`CMB_OPT_MARGIN_LOW]
			|=> margin_low_q == `CMB_MARGIN_LOW_VAL1;
	endproperty
	a_margin_low: assert property (p_margin_low) else $error("Margin low wrong.");

	property p_margin_high;
		cmd_valid && cmd_write && cmd_code == `CMB_CODE_RESTORE_ALL
			&& !nvm_opt_q[`CMB_OPT_MARGIN_HIGH]
			|=> margin_high_q == `CMB_MARGIN_HIGH_VAL0;
	endproperty
	a_margin_high: assert property (p_margin_high) else $error("Margin high wrong.");

	property p_store;
		cmd_valid && cmd_write && cmd_code == `CMB_CODE_STORE_ALL
			|=> nvm_misc_q == $past(misc_q);
	endproperty
	a_store: assert property (p_store) else $error("Options not stored.");

	property p_ov_latch;
		s_ov_taken |=> lowside_fet_on_q;
	endproperty
	a_ov_latch: assert property (p_ov_latch) else $error("FET not latched on.");

	property p_ov_hold;
		s_fet_held |=> lowside_fet_on_q;
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("FET released early.");

	property p_ov_release;
		lowside_fet_on_q && misc_q[`CMB_MISC_OV_BEHAVIOUR] && feedback_low && !ov_fault_det
			|=> !lowside_fet_on_q;
	endproperty
	a_ov_release: assert property (p_ov_release) else $error("FET not released.");

	property p_trim;
		misc_q[`CMB_MISC_TRIM_LSB +: 2] == 2'b10 |=> oc_trim_eighths_q == 3'h6;
	endproperty
	a_trim: assert property (p_trim) else $error("Trim wrong.");

	property p_ls_hold;
		driver_switching && sw_prev_q |=> $stable(level_shifter_on_q);
	endproperty
	a_ls_hold: assert property (p_ls_hold) else $error("Shifter changed.");

	property p_sync_out;
		misc_q[`CMB_MISC_SYNC_OUT] |=> sync_oe_q && sync_out_q == $past(freerun_q);
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("Sync not driven.");

	property p_sync_in;
		misc_q[`CMB_MISC_SYNC_IN] && !lost |=> pwm_clk_q == $past(sync_lvl);
	endproperty
	a_sync_in: assert property (p_sync_in) else $error("Not following sync.");

	property p_sync_mask;
		misc_q[`CMB_MISC_SYNC_MASK] |=> !sync_fault_q;
	endproperty
	a_sync_mask: assert property (p_sync_mask) else $error("Masked fault shown.");

	property p_ara;
		ara_done && opt_q[`CMB_OPT_AUTO_ALERT]
			&& !(cmd_valid && cmd_write && cmd_code == `CMB_CODE_CLEAR_FAULTS)
			|=> (alert_mask_q & $past(fault_sources)) == $past(fault_sources);
	endproperty
	a_ara: assert property (p_ara) else $error("Sources not masked.");

	property p_reserved;
		(misc_q & ~`CMB_MISC_WMASK) == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved bit set.");
endmodule : cmb_config

/* File: verilog/cmb_sync_edge.sv */
`timescale 1ns/1ps

module cmb_sync_edge (
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst,
	// Asynchronous input.
	input  wire logic async_in,
	// Synchronised level and rising-edge pulse.
	output logic      level_q,
	output logic      rise_q
);
	logic meta_q;
	logic sync2_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q  <= 1'b0;
			sync2_q <= 1'b0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
		end else begin
			meta_q  <= async_in;
			sync2_q <= meta_q;
			level_q <= sync2_q;
			rise_q  <= sync2_q & ~level_q;
		end
	end
endmodule : cmb_sync_edge
